// File: inc/sac_defines.svh
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// Register byte offsets on the bus, one aligned 32-bit word each.
`define SAC_OFF_CTRL      8'h00
`define SAC_OFF_REFPIN    8'h04
`define SAC_OFF_CLKFMT    8'h08
`define SAC_OFF_RES_HIGH  8'h0C
`define SAC_OFF_RES_LOW   8'h10
`define SAC_OFF_STATUS    8'h14

// Field positions.
`define SAC_CTRL_EN_BIT   0
`define SAC_CTRL_GO_BIT   1
`define SAC_CTRL_CH_LSB   2
`define SAC_REF_LSB       4
`define SAC_ALIGN_BIT     7
`define SAC_STAT_DONE_BIT 0
`define SAC_STAT_BUSY_BIT 1

// Reset values.
`define SAC_CTRL_RST      6'h00
`define SAC_REFPIN_RST    6'h00
`define SAC_CLKFMT_RST    4'h0
`define SAC_RESULT_RST    8'h00

// Timing in conversion bit periods.
`define SAC_CONV_TAD      4'hC
`define SAC_GAP_TAD       4'h2
`define SAC_RESULT_BITS   10

`endif

// File: inc/sac_pkg.sv
package sac_pkg;

    // Code 2'b11 is unused and falls back to idle.
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_CONV = 2'b01,
        SAC_GAP  = 2'b10
    } sac_state_t;

    typedef struct packed {
        logic [3:0] channel;
        logic       go;
        logic       enable;
    } sac_ctrl_t;

    typedef struct packed {
        logic [1:0] ref_sel;
        logic [3:0] pin_func;
    } sac_refpin_t;

    typedef struct packed {
        logic       align_right;
        logic [2:0] clk_sel;
    } sac_clkfmt_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } sac_wb_req_t;

endpackage

// File: src/sac_top.sv
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "sac_defines.svh"

// Notes on behaviour
// - Channel field bits 5-2 picks input 0-15.
// - Start flag begins conversion, hardware clears it.
// - Enable bit powers converter; clear shuts down.
// - Reference bits pick external negative/positive references.
// - Nonzero pin field k makes top k+1 inputs digital; zero makes none.
// - Unused register bits always read zero.
// - Alignment bit: one right, zero left.
// - Clock select picks oscillator divider or RC.
// - RC clock lets conversion continue in sleep.
// - Reset returns all registers, aborts conversion.
// - Completion loads result, clears start, sets done.
// - Two bit periods gap before next acquisition.
// - Conversion start disconnects holding capacitor.
// - Ten-bit code by successive approximation.
// - Clearing start aborts; results kept; gap, resample.
// - Each conversion takes twelve bit periods.

module sac_top
    import sac_pkg::*;
(
    input  wire logic                clk,                  // System clock, 25 MHz.
    input  wire logic                arst_n,               // Asynchronous reset.
    input  wire sac_pkg::sac_wb_req_t wb_req,              // Wishbone request group.
    output logic [31:0]              wb_dat_o,             // Wishbone read data.
    output logic                     wb_ack_o,             // Wishbone acknowledge.
    input  wire logic                comparator_in,        // Analog comparator result.
    input  wire logic                internal_rc_clock,    // Free RC clock from analog side.
    output logic                     converter_enable,     // Power to the analog core.
    output logic                     sample_connect,       // Holding capacitor on input.
    output logic [3:0]               input_channel_select, // Analog mux select.
    output logic [1:0]               reference_select,     // Reference configuration.
    output logic [15:0]              pin_digital,          // One per input: digital I/O.
    output logic [9:0]               dac_code,             // Trial code to the DAC.
    output logic                     conversion_done_flag  // Sticky done flag.
);

    import sac_pkg::*;

    // ************************************************************
    // Registers and state
    // ************************************************************

    sac_ctrl_t   ctrl_reg;
    sac_ctrl_t   ctrl_next;
    sac_refpin_t refpin_reg;
    sac_clkfmt_t clkfmt_reg;
    sac_state_t  state_reg;
    sac_state_t  state_next;
    logic [7:0]  res_high_reg;
    logic [7:0]  res_high_next;
    logic [7:0]  res_low_reg;
    logic [7:0]  res_low_next;
    logic        done_reg;
    logic        done_next;
    logic [9:0]  sar_reg;
    logic [9:0]  sar_next;
    logic [3:0]  tad_cnt_reg;
    logic [3:0]  tad_cnt_next;
    logic [5:0]  div_reg;
    logic        rc_s1_reg;
    logic        rc_s2_reg;
    logic        rc_s3_reg;
    logic        ack_reg;
    logic [31:0] rdat_reg;

    // ************************************************************
    // Bus decode
    // ************************************************************

    wire logic       bus_req   = wb_req.cyc & wb_req.stb & ~ack_reg;
    wire logic       bus_wr    = bus_req & wb_req.we & wb_req.sel[0];
    wire logic [7:0] wdat      = wb_req.dat[7:0];
    wire logic       hit_ctrl  = wb_req.adr == `SAC_OFF_CTRL;
    wire logic       hit_ref   = wb_req.adr == `SAC_OFF_REFPIN;
    wire logic       hit_clk   = wb_req.adr == `SAC_OFF_CLKFMT;
    wire logic       hit_rhi   = wb_req.adr == `SAC_OFF_RES_HIGH;
    wire logic       hit_rlo   = wb_req.adr == `SAC_OFF_RES_LOW;
    wire logic       hit_stat  = wb_req.adr == `SAC_OFF_STATUS;
    wire logic       wr_ctrl   = bus_wr & hit_ctrl;
    wire logic       wr_ref    = bus_wr & hit_ref;
    wire logic       wr_clk    = bus_wr & hit_clk;
    wire logic       wr_rhi    = bus_wr & hit_rhi;
    wire logic       wr_rlo    = bus_wr & hit_rlo;
    wire logic       wr_stat   = bus_wr & hit_stat;

    wire logic [7:0] ctrl_rd   = {2'b00, ctrl_reg};
    wire logic [7:0] ref_rd    = {2'b00, refpin_reg};
    wire logic [7:0] clk_rd    = {clkfmt_reg.align_right, 4'h0, clkfmt_reg.clk_sel};
    wire logic       busy      = state_reg != SAC_IDLE;
    wire logic [7:0] stat_rd   = {6'h00, busy, done_reg};

    // Unmapped addresses answer with zero data and ignore writes.
    wire logic [7:0] rd_mux    = hit_ctrl ? ctrl_rd :
                                 hit_ref  ? ref_rd :
                                 hit_clk  ? clk_rd :
                                 hit_rhi  ? res_high_reg :
                                 hit_rlo  ? res_low_reg :
                                 hit_stat ? stat_rd : 8'h00;

    // ************************************************************
    // Conversion clock
    // ************************************************************

    wire logic [2:0] div_exp   = {ctrl_sel_hi(clkfmt_reg.clk_sel), 1'b0}
                                 + 3'h1 + {2'b00, clkfmt_reg.clk_sel[2]};
    wire logic [5:0] div_mask  = 6'(7'h01 << div_exp) - 6'h01;
    wire logic       osc_tick  = (div_reg & div_mask) == div_mask;
    wire logic       use_rc    = clkfmt_reg.clk_sel[1:0] == 2'b11;
    wire logic       rc_tick   = rc_s2_reg & ~rc_s3_reg;
    wire logic       tad_tick  = use_rc ? rc_tick : osc_tick;

    function automatic logic [1:0] ctrl_sel_hi(input logic [2:0] sel);
        ctrl_sel_hi = sel[1:0];
    endfunction

    // ************************************************************
    // Successive approximation
    // ************************************************************

    wire logic       trial_on  = (tad_cnt_reg >= 4'h1) && (tad_cnt_reg <= 4'hA);
    wire logic [9:0] trial_bit = trial_on ? (10'h200 >> (tad_cnt_reg - 4'h1)) : 10'h000;
    wire logic       last_tad  = tad_cnt_reg == (`SAC_CONV_TAD - 4'h1);
    wire logic       gap_end   = tad_cnt_reg == (`SAC_GAP_TAD - 4'h1);
    wire logic       converting = state_reg == SAC_CONV;
    wire logic       complete  = converting & ctrl_reg.enable & ctrl_reg.go
                                 & tad_tick & last_tad;

    wire logic [7:0] fmt_high  = clkfmt_reg.align_right ? {6'h00, sar_reg[9:8]}
                                                         : sar_reg[9:2];
    wire logic [7:0] fmt_low   = clkfmt_reg.align_right ? sar_reg[7:0]
                                                         : {sar_reg[1:0], 6'h00};

    // ************************************************************
    // Next-state logic
    // ************************************************************

    always_comb begin
        state_next   = state_reg;
        tad_cnt_next = tad_cnt_reg;
        sar_next     = sar_reg;
        unique case (state_reg)
            SAC_IDLE: begin
                if (ctrl_reg.enable && ctrl_reg.go) begin
                    state_next   = SAC_CONV;
                    tad_cnt_next = 4'h0;
                    sar_next     = 10'h000;
                end
            end
            SAC_CONV: begin
                if (!ctrl_reg.enable) begin
                    state_next = SAC_IDLE;
                end else if (!ctrl_reg.go) begin
                    state_next   = SAC_GAP;
                    tad_cnt_next = 4'h0;
                end else if (tad_tick) begin
                    if (last_tad) begin
                        state_next   = SAC_GAP;
                        tad_cnt_next = 4'h0;
                    end else begin
                        tad_cnt_next = tad_cnt_reg + 4'h1;
                    end
                    if (comparator_hit()) begin
                        sar_next = sar_reg | trial_bit;
                    end
                end
            end
            SAC_GAP: begin
                if (!ctrl_reg.enable) begin
                    state_next = SAC_IDLE;
                end else if (tad_tick) begin
                    if (gap_end) begin
                        state_next = SAC_IDLE;
                    end else begin
                        tad_cnt_next = tad_cnt_reg + 4'h1;
                    end
                end
            end
            default: begin
                state_next = SAC_IDLE;
            end
        endcase
    end

    // The comparator is high when the held input is at or above the trial code.
    // It answers the trial code that this clock drives, so it is read as a same-clock input.
    // Two synchroniser stages would add a third cycle per bit and break divide by two.
    function automatic logic comparator_hit();
        comparator_hit = comparator_in;
    endfunction

    always_comb begin
        ctrl_next = ctrl_reg;
        if (complete) begin
            ctrl_next.go = 1'b0;
        end
        if (!ctrl_reg.enable) begin
            ctrl_next.go = 1'b0;
        end
        // A software write wins over the hardware clear of the same cycle.
        if (wr_ctrl) begin
            ctrl_next.channel = wdat[5:2];
            ctrl_next.enable  = wdat[`SAC_CTRL_EN_BIT];
            ctrl_next.go      = wdat[`SAC_CTRL_GO_BIT] & ctrl_reg.enable
                                & wdat[`SAC_CTRL_EN_BIT];
        end
    end

    always_comb begin
        res_high_next = wr_rhi ? wdat : res_high_reg;
        res_low_next  = wr_rlo ? wdat : res_low_reg;
        done_next     = done_reg;
        if (wr_stat && wdat[`SAC_STAT_DONE_BIT]) begin
            done_next = 1'b0;
        end
        if (complete) begin
            res_high_next = fmt_high;
            res_low_next  = fmt_low;
            done_next     = 1'b1;
        end
    end

    // ************************************************************
    // Flip-flops
    // ************************************************************

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg     <= `SAC_CTRL_RST;
            refpin_reg   <= `SAC_REFPIN_RST;
            clkfmt_reg   <= `SAC_CLKFMT_RST;
            state_reg    <= SAC_IDLE;
            res_high_reg <= `SAC_RESULT_RST;
            res_low_reg  <= `SAC_RESULT_RST;
            done_reg     <= 1'b0;
            sar_reg      <= 10'h000;
            tad_cnt_reg  <= 4'h0;
        end else begin
            ctrl_reg     <= ctrl_next;
            refpin_reg   <= wr_ref ? wdat[5:0] : refpin_reg;
            clkfmt_reg   <= wr_clk ? {wdat[`SAC_ALIGN_BIT], wdat[2:0]} : clkfmt_reg;
            state_reg    <= state_next;
            res_high_reg <= res_high_next;
            res_low_reg  <= res_low_next;
            done_reg     <= done_next;
            sar_reg      <= sar_next;
            tad_cnt_reg  <= tad_cnt_next;
        end
    end

    // The RC clock pin from the analog side is resynchronised before use; the comparator is not.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg    <= 6'h00;
            rc_s1_reg  <= 1'b0;
            rc_s2_reg  <= 1'b0;
            rc_s3_reg  <= 1'b0;
        end else begin
            div_reg    <= div_reg + 6'h01;
            rc_s1_reg  <= internal_rc_clock;
            rc_s2_reg  <= rc_s1_reg;
            rc_s3_reg  <= rc_s2_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= bus_req;
            rdat_reg <= {24'h00_0000, rd_mux};
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    assign wb_ack_o             = ack_reg;
    assign wb_dat_o             = rdat_reg;
    assign converter_enable     = ctrl_reg.enable;
    assign sample_connect       = ctrl_reg.enable & (state_reg == SAC_IDLE);
    assign input_channel_select = ctrl_reg.channel;
    assign reference_select     = refpin_reg.ref_sel;
    assign dac_code             = sar_reg | trial_bit;
    assign conversion_done_flag = done_reg;

    for (genvar i = 0; i < 16; i++) begin : g_pin
        assign pin_digital[i] = (refpin_reg.pin_func != 4'h0)
                                && ((5'(i) + {1'b0, refpin_reg.pin_func}) >= 5'd15);
    end

endmodule

// File: verification/sac_analog_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Behavioural sample-and-hold, comparator and RC clock.
// ****************************************************************
module sac_analog_model #(
    parameter int RC_HALF_NS = 100
) (
    input  wire logic       converter_enable, // Core powered.
    input  wire logic       sample_connect,   // Sampling switch closed.
    input  wire logic [9:0] dac_code,         // Trial code.
    input  wire logic [9:0] level,            // Input voltage in code steps.
    output logic            comparator_in,    // Held sample at or above trial.
    output logic            internal_rc_clock // Free RC clock.
);
    logic [9:0] held_reg;

    // The RC clock never stops.
    // Its phase is offset so that no edge meets a system clock edge.
    initial begin
        internal_rc_clock = 1'b0;
        #(RC_HALF_NS / 3);
        forever #(RC_HALF_NS) internal_rc_clock = ~internal_rc_clock;
    end

    always @(sample_connect or level) begin
        if (sample_connect) begin
            held_reg = level;
        end
    end

    // An unpowered core gives a toggling, useless answer.
    assign comparator_in = converter_enable ? (held_reg >= dac_code) : internal_rc_clock;
endmodule

// File: verification/sac_top_monitor.sv
`timescale 1ns/1ps
module sac_top_monitor
    import sac_pkg::*;
(
    input wire logic                 clk,                  // System clock.
    input wire logic                 arst_n,               // Async reset.
    input wire sac_pkg::sac_wb_req_t wb_req,               // Bus request.
    input wire logic [31:0]          wb_dat_o,             // Read data.
    input wire logic                 wb_ack_o,             // Acknowledge.
    input wire logic                 converter_enable,     // Core power.
    input wire logic                 sample_connect,       // Sampling switch.
    input wire logic [3:0]           input_channel_select, // Mux select.
    input wire logic [1:0]           reference_select,     // Reference choice.
    input wire logic [15:0]          pin_digital,          // Digital pins.
    input wire logic                 conversion_done_flag  // Done flag.
);
    logic wr_ok;

    // A write lands at the edge that raises ack, so it shows while ack is high.
    assign wr_ok = wb_ack_o && wb_req.we && wb_req.sel[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chan_write_a: assert property (wr_ok && wb_req.adr == 8'h00 |->
        input_channel_select == wb_req.dat[5:2]) else $error("channel not written");
    en_write_a: assert property (wr_ok && wb_req.adr == 8'h00 |->
        converter_enable == wb_req.dat[0]) else $error("enable not written");
    off_idle_a: assert property (!converter_enable |-> !sample_connect)
        else $error("sampling while off");
    ref_write_a: assert property (wr_ok && wb_req.adr == 8'h04 |->
        reference_select == wb_req.dat[5:4]) else $error("reference not written");
    pin_map_a: assert property (wr_ok && wb_req.adr == 8'h04 |-> pin_digital ==
        ((wb_req.dat[3:0] == 4'h0) ? 16'h0000 : (16'hFFFF << (4'hF - wb_req.dat[3:0]))))
        else $error("pin map wrong");
    pad_zero_a: assert property (wb_ack_o && !wb_req.we |-> wb_dat_o[31:8] == 24'h0 &&
        (wb_req.adr > 8'h04 || wb_dat_o[7:6] == 2'h0) &&
        (wb_req.adr != 8'h08 || wb_dat_o[6:3] == 4'h0)) else $error("unused bits set");
    reset_state_a: assert property ($rose(arst_n) |-> !converter_enable &&
        !conversion_done_flag && pin_digital == 16'h0000) else $error("reset state wrong");
    done_gap_a: assert property ($rose(conversion_done_flag) |-> !sample_connect [*3])
        else $error("gap too short");
    conv_len_a: assert property ($fell(sample_connect) && converter_enable |=>
        !$rose(conversion_done_flag) [*8]) else $error("conversion too short");
    off_no_done_a: assert property (!converter_enable |=> !$rose(conversion_done_flag))
        else $error("done while off");
endmodule

bind sac_top sac_top_monitor i_sac_top_monitor (.clk(clk), .arst_n(arst_n), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .converter_enable(converter_enable),
    .sample_connect(sample_connect), .input_channel_select(input_channel_select),
    .reference_select(reference_select), .pin_digital(pin_digital),
    .conversion_done_flag(conversion_done_flag));

// File: verification/sar_adc_control_tb.sv
`timescale 1ns/1ps
module sar_adc_control_tb;
    import sac_pkg::*;
    logic        clk;
    logic        arst_n;
    sac_wb_req_t wb_req;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        comparator_in;
    logic        internal_rc_clock;
    logic        converter_enable;
    logic        sample_connect;
    logic [3:0]  input_channel_select;
    logic [1:0]  reference_select;
    logic [15:0] pin_digital;
    logic [9:0]  dac_code;
    logic        conversion_done_flag;
    logic [9:0]  level;
    logic [31:0] rd;
    int          bad_count;
    int          checks_done;
    int          cyc_cnt;
    int          t0;
    int          div;
    int          n;
    // Rows: address, write data, expected read back.
    logic [23:0] rows [9] = '{24'h04FF3F, 24'h040000, 24'h08FF87, 24'h080000, 24'h0CA5A5,
                              24'h105A5A, 24'h00FE3C, 24'h000000, 24'h18FF00};

    sac_top i_sac_top (.clk(clk), .arst_n(arst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .comparator_in(comparator_in), .internal_rc_clock(internal_rc_clock),
        .converter_enable(converter_enable), .sample_connect(sample_connect),
        .input_channel_select(input_channel_select), .reference_select(reference_select),
        .pin_digital(pin_digital), .dac_code(dac_code), .conversion_done_flag(conversion_done_flag));
    sac_analog_model i_sac_analog_model (.converter_enable(converter_enable),
        .sample_connect(sample_connect), .dac_code(dac_code), .level(level),
        .comparator_in(comparator_in), .internal_rc_clock(internal_rc_clock));

    always #20 clk = ~clk;
    always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

    task automatic end_sim;
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    // Classic single cycle; the bench never assumes the slave's latency.
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int k;
        k = 0;
        wb_req <= '{1'b1, 1'b1, w, 4'h1, a, {24'h0, d}};
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_req <= '0;
        @(posedge clk);
        if (k >= 20) begin
            bad_count++;
            end_sim();
        end
    endtask

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        wb_req = '0;
        level = 10'h000;
        bad_count = 0;
        checks_done = 0;
        cyc_cnt = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            bus(rows[i][23:16], 1'b1, rows[i][15:8]);
            bus(rows[i][23:16], 1'b0, 8'h00);
            chk(rd, {24'h0, rows[i][7:0]});
        end
        for (int k = 0; k < 16; k++) begin
            bus(8'h04, 1'b1, 8'(k));
            chk({16'h0, pin_digital}, (k == 0) ? 32'h0 : {16'h0, 16'hFFFF << (15 - k)});
        end
        bus(8'h04, 1'b1, 8'h20);
        chk({30'h0, reference_select}, 32'h2);
        for (int cs = 0; cs < 8; cs++) begin
            level <= 10'h2D3 ^ 10'(cs * 65);
            bus(8'h08, 1'b1, {cs[0], 4'h0, 3'(cs)});
            bus(8'h00, 1'b1, 8'h15);
            chk({28'h0, input_channel_select}, 32'h5);
            repeat (140) @(posedge clk);
            t0 = cyc_cnt;
            bus(8'h00, 1'b1, 8'h17);
            n = 0;
            do begin
                bus(8'h00, 1'b0, 8'h00);
                n++;
            end while (rd[1] === 1'b1 && n < 400);
            if (rd[1] === 1'b1) begin
                bad_count++;
                end_sim();
            end
            div = (cs % 4 == 3) ? 5 : 2 << (2 * (cs % 4) + cs / 4);
            chk(32'(cyc_cnt - t0 >= 11 * div && cyc_cnt - t0 <= 13 * div + 12), 32'h1);
            bus(8'h0C, 1'b0, 8'h00);
            chk(rd, cs[0] ? {30'h0, level[9:8]} : {24'h0, level[9:2]});
            bus(8'h10, 1'b0, 8'h00);
            chk(rd, cs[0] ? {24'h0, level[7:0]} : {24'h0, level[1:0], 6'h0});
            chk({31'h0, conversion_done_flag}, 32'h1);
            bus(8'h14, 1'b1, 8'h01);
            chk({31'h0, conversion_done_flag}, 32'h0);
        end
        bus(8'h0C, 1'b1, 8'h33);
        bus(8'h10, 1'b1, 8'h44);
        bus(8'h08, 1'b1, 8'h06);
        bus(8'h00, 1'b1, 8'h17);
        repeat (300) @(posedge clk);
        bus(8'h00, 1'b1, 8'h15);
        chk({31'h0, sample_connect}, 32'h0);
        n = 0;
        while (sample_connect !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            bad_count++;
            end_sim();
        end
        chk(32'(n >= 60 && n < 400), 32'h1);
        bus(8'h0C, 1'b0, 8'h00);
        chk(rd, 32'h33);
        bus(8'h10, 1'b0, 8'h00);
        chk(rd, 32'h44);
        chk({31'h0, conversion_done_flag}, 32'h0);
        bus(8'h00, 1'b1, 8'h17);
        repeat (50) @(posedge clk);
        arst_n <= 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        bus(8'h00, 1'b0, 8'h00);
        chk(rd, 32'h0);
        chk({31'h0, converter_enable}, 32'h0);
        bus(8'h08, 1'b0, 8'h00);
        chk(rd, 32'h0);
        end_sim();
    end

    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_sim();
    end
endmodule
